// ### logic/ppg_pulse_gen.sv
`timescale 1ns/1ps
`include "ppg_consts.svh"
module ppg_pulse_gen #(
  parameter int NUM_CH = `PPG_NUM_CH, // Channel count
  parameter int DIV_W  = `PPG_DIV_W   // Prescaler width
) (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rst_n,
  input  wire ppg_pkg::ppg_wr_t [1:0]   i_wr,
  input  wire logic [1:0]               i_channel_run,
  input  wire logic                     i_cascade_select,
  input  wire logic                     i_output_and_select,
  output logic [1:0]                    o_pulse_output_pin,
  output logic [1:0]                    o_channel_interrupt,
  output ppg_pkg::ppg_mode_t [1:0]      o_channel_mode_reg,
  output ppg_pkg::ppg_rd_t [1:0]        o_rd
);

  // Free running prescaler shared by both channels
  logic [DIV_W-1:0] pre_r;
  logic [DIV_W-1:0] pre_nxt;

  // Divider taps, index is the clock select code
  wire  [7:0]       taps;

  // Per channel state
  ppg_pkg::ppg_mode_t [1:0] mode_r;     // Channel mode register
  logic [1:0][7:0]  cnt_r;              // Up counter
  logic [1:0][7:0]  duty_eff_r;         // Duty value in use
  logic [1:0][7:0]  duty_buf_r;         // Duty last written
  logic [1:0][7:0]  cyc_eff_r;          // Cycle value in use
  logic [1:0][7:0]  cyc_buf_r;          // Cycle last written
  logic [1:0]       duty_eq_prev_r;     // Duty equality last cycle
  logic [1:0]       cyc_eq_prev_r;      // Cycle equality last cycle
  logic [1:0]       out_r;              // Channel output level

  // Prescaler next value
  assign pre_nxt = pre_r + {{(DIV_W-1){1'b0}}, 1'b1};

  // Taps from slowest (code 0) to every cycle (code 7)
  assign taps = {1'b1,
                 &pre_r[0],
                 &pre_r[1:0],
                 &pre_r[3:0],
                 &pre_r[5:0],
                 &pre_r[7:0],
                 &pre_r[9:0],
                 &pre_r[10:0]};

  // Prescaler counter
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      // Decode of this channel's controls
      wire       run      = i_channel_run[ch];
      wire       pulse_md = (mode_r[ch].mode_field == `PPG_MODE_PULSE)
                            && !i_cascade_select;
      wire       active   = run && pulse_md;
      wire       tick     = active && taps[mode_r[ch].clock_select_field];
      wire       buf_on   = mode_r[ch].buffer_enable;
      wire       init_lvl = mode_r[ch].initial_level_select;
      // Writes go straight to the compare unless buffered and running
      wire       direct   = !run || !buf_on;
      // Equality is level; a match fires on its rising edge only
      wire       duty_eq  = (cnt_r[ch] == duty_eff_r[ch]);
      wire       cyc_eq   = (cnt_r[ch] == cyc_eff_r[ch]);
      wire       duty_hit = active && duty_eq && !duty_eq_prev_r[ch];
      wire       cyc_hit  = active && cyc_eq && !cyc_eq_prev_r[ch];
      wire [7:0] cnt_nxt  = cnt_r[ch] + 8'h01;

      // Mode register, locked while the channel runs
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          mode_r[ch] <= `PPG_MODE_RST;
        end else if (i_wr[ch].mode_wr && !run) begin
          mode_r[ch] <= i_wr[ch].data;
        end
      end

      // Up counter: cleared when stopped or on cycle match
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          cnt_r[ch] <= `PPG_BYTE_RST;
        end else if (!active) begin
          cnt_r[ch] <= `PPG_BYTE_RST;
        end else if (cyc_hit) begin
          cnt_r[ch] <= `PPG_BYTE_RST;
        end else if (tick) begin
          cnt_r[ch] <= cnt_nxt;
        end
      end

      // Equality history; a fresh equal write gives a new edge
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          duty_eq_prev_r[ch] <= 1'b0;
          cyc_eq_prev_r[ch]  <= 1'b0;
        end else if (!active) begin
          duty_eq_prev_r[ch] <= 1'b0;
          cyc_eq_prev_r[ch]  <= 1'b0;
        end else begin
          duty_eq_prev_r[ch] <= duty_eq;
          cyc_eq_prev_r[ch]  <= cyc_eq;
        end
      end

      // Duty compare buffer and effective value
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          duty_buf_r[ch] <= `PPG_BYTE_RST;
          duty_eff_r[ch] <= `PPG_BYTE_RST;
        end else if (i_wr[ch].duty_wr) begin
          duty_buf_r[ch] <= i_wr[ch].data;
          if (direct) begin
            duty_eff_r[ch] <= i_wr[ch].data;
          end else if (cyc_hit) begin
            duty_eff_r[ch] <= duty_buf_r[ch];
          end
        end else if (cyc_hit && buf_on) begin
          duty_eff_r[ch] <= duty_buf_r[ch];
        end
      end

      // Cycle compare buffer and effective value
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          cyc_buf_r[ch] <= `PPG_BYTE_RST;
          cyc_eff_r[ch] <= `PPG_BYTE_RST;
        end else if (i_wr[ch].cycle_wr) begin
          cyc_buf_r[ch] <= i_wr[ch].data;
          if (direct) begin
            cyc_eff_r[ch] <= i_wr[ch].data;
          end else if (cyc_hit) begin
            cyc_eff_r[ch] <= cyc_buf_r[ch];
          end
        end else if (cyc_hit && buf_on) begin
          cyc_eff_r[ch] <= cyc_buf_r[ch];
        end
      end

      // Channel output level and interrupt pulse
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          out_r[ch]               <= 1'b0;
          o_channel_interrupt[ch] <= 1'b0;
        end else begin
          o_channel_interrupt[ch] <= cyc_hit;
          if (!active) begin
            out_r[ch] <= init_lvl;
          end else if (cyc_hit) begin
            out_r[ch] <= init_lvl;
          end else if (duty_hit) begin
            out_r[ch] <= !init_lvl;
          end
        end
      end

      // Readback, buffered value when buffering is on
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          o_rd[ch] <= '0;
        end else begin
          o_rd[ch].duty  <= buf_on ? duty_buf_r[ch] : duty_eff_r[ch];
          o_rd[ch].cycle <= buf_on ? cyc_buf_r[ch] : cyc_eff_r[ch];
          o_rd[ch].count <= cnt_r[ch];
        end
      end
    end
  endgenerate

  // Mode readback copy
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_channel_mode_reg <= '0;
    end else begin
      o_channel_mode_reg <= mode_r;
    end
  end

  // Pins: second pin may carry the AND of both channels
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_pulse_output_pin <= 2'h0;
    end else begin
      o_pulse_output_pin[0] <= out_r[0];
      o_pulse_output_pin[1] <= i_output_and_select ?
                               (out_r[0] & out_r[1]) : out_r[1];
    end
  end

endmodule : ppg_pulse_gen

// ### include/ppg_consts.svh
`ifndef PPG_CONSTS_SVH
`define PPG_CONSTS_SVH
// Mode field code selecting the pulse generator
`define PPG_MODE_PULSE  2'h2
// Reset value of the channel mode register
`define PPG_MODE_RST    8'h00
// Reset value of counter and compare registers
`define PPG_BYTE_RST    8'h00
// Width of the source clock prescaler
`define PPG_DIV_W       11
// Number of timer channels
`define PPG_NUM_CH      2
`endif

// ### include/ppg_pkg.sv
`include "ppg_consts.svh"
package ppg_pkg;
  // Channel mode register layout, msb first
  typedef struct packed {
    logic [1:0] mode_field;           // Operating mode
    logic [2:0] clock_select_field;   // Source clock tap
    logic       event_input_select;   // Must stay zero here
    logic       buffer_enable;        // Double buffer on
    logic       initial_level_select; // Idle pin level
  } ppg_mode_t;

  // One channel's software write port
  typedef struct packed {
    logic       duty_wr;  // Write duty compare
    logic       cycle_wr; // Write cycle compare
    logic       mode_wr;  // Write channel mode
    logic [7:0] data;     // Write data
  } ppg_wr_t;

  // One channel's readback
  typedef struct packed {
    logic [7:0] duty;  // Duty compare readback
    logic [7:0] cycle; // Cycle compare readback
    logic [7:0] count; // Up counter value
  } ppg_rd_t;
endpackage : ppg_pkg

// ### test/ppg_chk.sv
`timescale 1ns/1ps
// Port-level watch on the pulse generator
module ppg_chk (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst_n,
  input  wire logic [1:0]              i_channel_run,
  input  wire logic                    i_output_and_select,
  input  wire logic [1:0]              o_pulse_output_pin,
  input  wire logic [1:0]              o_channel_interrupt,
  input  wire ppg_pkg::ppg_mode_t [1:0] o_channel_mode_reg,
  input  wire ppg_pkg::ppg_rd_t [1:0]  o_rd
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Run bit of channel 0 as seen one and two edges back
  logic run_d1_r;
  logic run_d2_r;
  // Run history, cleared by reset so stop3 is known at once
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      run_d1_r <= 1'b0;
      run_d2_r <= 1'b0;
    end else begin
      run_d1_r <= i_channel_run[0];
      run_d2_r <= run_d1_r;
    end
  end
  // Channel 0 stopped for three edges
  wire stop3 = !i_channel_run[0] && !run_d1_r && !run_d2_r;
  idle_level_a : assert property (stop3 &&
    $past(o_channel_mode_reg[0], 3) == o_channel_mode_reg[0] |->
    o_pulse_output_pin[0] == o_channel_mode_reg[0].initial_level_select)
    else $error("idle pin level wrong");
  stop_count_a : assert property (stop3 |-> o_rd[0].count == 8'h00)
    else $error("stopped counter not zero");
  stop_quiet_a : assert property (stop3 |-> !o_channel_interrupt[0])
    else $error("interrupt while stopped");
  irq_single_a : assert property (o_channel_interrupt[0] |=>
    !o_channel_interrupt[0]) else $error("interrupt longer than one cycle");
  irq_clear_a : assert property (o_channel_interrupt[0] |=>
    o_rd[0].count == 8'h00) else $error("counter not cleared on match");
  irq_level_a : assert property (o_channel_interrupt[0] |-> ##[0:2]
    o_pulse_output_pin[0] == o_channel_mode_reg[0].initial_level_select)
    else $error("pin not back at idle level");
  mode_lock_a : assert property (i_channel_run[0] &&
    $past(i_channel_run[0]) && $past(i_channel_run[0], 2) |->
    $stable(o_channel_mode_reg[0])) else $error("mode changed while running");
  and_pin_a : assert property (i_output_and_select &&
    $past(i_output_and_select) && o_pulse_output_pin[1] |->
    o_pulse_output_pin[0]) else $error("pin 1 not the AND of outputs");
  irq_single1_a : assert property (o_channel_interrupt[1] |=>
    !o_channel_interrupt[1]) else $error("channel 1 interrupt too long");
endmodule : ppg_chk

// ### test/tb_top.sv
`timescale 1ns/1ps
`include "ppg_consts.svh"
module tb_top;
  logic                     clk = 1'b0;  // System clock
  logic                     rst_n = 1'b0; // Reset, active low
  logic                     and_sel = 1'b0; // AND onto pin 1
  logic [1:0]               run = 2'h0;  // Run bits
  ppg_pkg::ppg_wr_t [1:0]   wr = '0;     // Write strobes
  logic [1:0]               pin, irq;    // Pin levels, interrupts
  ppg_pkg::ppg_mode_t [1:0] mode;        // Mode readback
  ppg_pkg::ppg_rd_t [1:0]   rd;          // Compare readback
  int mismatches = 0, tests_run = 0, n, h, c, d, ch;
  logic lv;
  ppg_pulse_gen uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_wr(wr),
    .i_channel_run(run), .i_cascade_select(1'b0),
    .i_output_and_select(and_sel), .o_pulse_output_pin(pin),
    .o_channel_interrupt(irq), .o_channel_mode_reg(mode), .o_rd(rd));
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  // Compare one value
  task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk
  // One-cycle write: k 0 mode, 1 cycle, 2 duty
  task automatic wr_t(int k, logic [7:0] v);
    wr[ch] = '0;
    wr[ch].data = v;
    wr[ch][8 + k] = 1'b1;
    @(negedge clk);
    wr[ch] = '0;
  endtask : wr_t
  // Mode write: pulse mode, every-cycle tap, event input zero
  task automatic md(logic dbe);
    wr_t(0, {`PPG_MODE_PULSE, 3'h7, 1'b0, dbe, lv});
  endtask : md
  // Cycles to next interrupt and cycles off idle level
  task automatic gap(output int n, output int h);
    n = 0;
    h = 0;
    do begin
      @(negedge clk);
      n++;
      h += int'(pin[ch] !== lv);
    end while (irq[ch] !== 1'b1 && n < 600);
  endtask : gap
  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // Watchdog
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  initial begin
    void'($urandom(31674));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk("mode_rst", 9'h000, 9'(mode[0]));
    // Random pulses on both channels and both idle levels
    for (int i = 0; i < 4; i++) begin
      ch = i % 2;
      lv = 1'(i / 2);
      c = 3 + $urandom % 38;
      d = 1 + $urandom % (c - 1);
      md(1'b0);
      wr_t(1, 8'(c));
      wr_t(2, 8'(d));
      repeat (4) @(negedge clk);
      chk("idle_pin", 9'(lv), 9'(pin[ch]));
      run[ch] = 1'b1;
      gap(n, h);
      gap(n, h);
      chk("period", 9'(c + 1), 9'(n));
      chk("high_time", 9'(c - d), 9'(h));
      lv = ~lv;
      md(1'b0);
      lv = ~lv;
      repeat (3) @(negedge clk);
      chk("mode_lock", 9'(lv), 9'(mode[ch].initial_level_select));
      run[ch] = 1'b0;
      repeat (4) @(negedge clk);
      chk("stop_count", 9'h000, 9'(rd[ch].count));
      chk("stop_pin", 9'(lv), 9'(pin[ch]));
      $display("pulse test %0d done", i);
    end
    // Buffered: running write waits for the match
    ch = 0;
    lv = 1'b0;
    md(1'b1);
    wr_t(1, 8'h1E);
    wr_t(2, 8'h01);
    repeat (2) @(negedge clk);
    chk("stopped_wr", 9'h01E, 9'(rd[0].cycle));
    run[0] = 1'b1;
    gap(n, h);
    wr_t(1, 8'h02);
    repeat (3) @(negedge clk);
    chk("buf_read", 9'h002, 9'(rd[0].cycle));
    gap(n, h);
    chk("old_period", 9'd27, 9'(n));
    gap(n, h);
    chk("new_period", 9'd3, 9'(n));
    $display("buffer test done");
    // Unbuffered: value below count waits for wrap
    run[0] = 1'b0;
    repeat (2) @(negedge clk);
    md(1'b0);
    wr_t(1, 8'hC8);
    run[0] = 1'b1;
    gap(n, h);
    repeat (50) @(negedge clk);
    wr_t(1, 8'h0A);
    gap(n, h);
    chk("wrap_period", 9'd216, 9'(n));
    $display("direct write test done");
    // Both channels onto pin 1
    and_sel = 1'b1;
    run = 2'h3;
    h = 0;
    repeat (300) begin
      @(negedge clk);
      h += int'(pin[1] & ~pin[0]);
    end
    chk("and_pin", 9'h000, 9'(h));
    $display("and test done");
    final_report();
  end
endmodule : tb_top
bind ppg_pulse_gen ppg_chk chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_channel_run(i_channel_run), .i_output_and_select(i_output_and_select),
  .o_pulse_output_pin(o_pulse_output_pin), .o_rd(o_rd),
  .o_channel_interrupt(o_channel_interrupt),
  .o_channel_mode_reg(o_channel_mode_reg));
